// ===== rtl/ebsu_pkg.sv
// Shared constants and types of the external bus strobe unit
package ebsu_pkg;
  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 16;
  localparam int AREA_N  = 8;
  localparam int AREA_W  = 3;
  localparam int LANE_N  = 2;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam int A0_BIT  = 0;
  localparam logic [AREA_N-1:0] AREA_IDLE = 8'hff;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 24'h00_0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [3:0] BCLK_HALF = 4'h1;
  typedef enum logic { EBSU_MODE_LANE, EBSU_MODE_SINGLE } ebsu_mode_t;
  typedef enum { EBSU_IDLE, EBSU_SETUP, EBSU_STROBE, EBSU_HOLD } ebsu_state_t;
endpackage : ebsu_pkg

// ===== rtl/ebsu_req_if.sv
// Request and answer bundle between the strobe unit and its pin stage
`timescale 1ns/100ps
interface ebsu_req_if;
  import ebsu_pkg::*;
  logic                strobe_on;
  logic                is_write;
  logic [LANE_N-1:0]   lanes;
  ebsu_mode_t          mode;
  logic                bclk_rise;
  modport ctrl (output strobe_on, is_write, lanes, mode, input bclk_rise);
  modport pins (input strobe_on, is_write, lanes, mode, output bclk_rise);
endinterface : ebsu_req_if

// ===== rtl/ebsu_bclk_gen.sv
// Bus clock divider feeding the external clock pin
`timescale 1ns/100ps
module ebsu_bclk_gen (
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      bclk_q,
  output logic      rise_q
);
  import ebsu_pkg::*;
  logic [3:0] cnt_q, cnt_d;
  logic       bclk_d, rise_d;

  always_comb begin
    cnt_d  = cnt_q + 4'h1;
    bclk_d = bclk_q;
    rise_d = 1'b0;
    if (cnt_q == BCLK_HALF) begin
      cnt_d  = 4'h0;
      bclk_d = ~bclk_q;
      rise_d = ~bclk_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      bclk_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      bclk_q <= bclk_d;
      rise_q <= rise_d;
    end
  end
endmodule : ebsu_bclk_gen

// ===== rtl/ebsu_top.sv
// External bus strobe unit: pin-level master of the external memory bus
// Functional notes
// RQ1 - Read strobe is low for the whole of an external read; the code drives it low in the strobe phase only, high in setup and hold.
// RQ2 - In per-lane mode the low write strobe goes low only when byte 0 carries write data.
// RQ3 - In per-lane mode the high write strobe goes low only when byte 1 carries write data.
// RQ4 - In single-strobe mode one write strobe is low for any write, whatever the lanes.
// RQ5 - In single-strobe mode the lane enables follow the valid bytes of the access.
// RQ6 - The lane enables act on reads as well as writes.
// RQ7 - The shared pin carries address bit 0 in per-lane mode and the low enable otherwise.
// RQ8 - Software must not combine single-strobe mode with an 8-bit bus; that is undefined.
// RQ9 - Eight active-low area selects; the one of the accessed area goes low.
// RQ10 - A low wait input during an access stretches it for as long as it is held.
// RQ11 - The access address goes out on 24 address lines.
// RQ12 - Data lines are driven on writes and sampled on reads.
// RQ13 - The bus clock is driven out on its own pin.
// RQ14 - All strobes, enables and selects are active low and idle high between accesses.
`timescale 1ns/100ps
module ebsu_top (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [ebsu_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [ebsu_pkg::LANE_N-1:0]   req_lanes,
  input  wire logic [ebsu_pkg::AREA_W-1:0]   req_area,
  input  wire logic [ebsu_pkg::DATA_W-1:0]   req_wdata,
  input  wire logic                          single_strobe_mode,
  output logic                               req_ready,
  output logic                               rsp_valid,
  output logic [ebsu_pkg::DATA_W-1:0]        rsp_rdata,
  output logic [ebsu_pkg::ADDR_W-1:0]        address_lines,
  output logic [ebsu_pkg::DATA_W-1:0]        data_lines_out,
  output logic                               data_lines_oe,
  input  wire logic [ebsu_pkg::DATA_W-1:0]   data_lines_in,
  output logic                               read_strobe_n,
  output logic                               low_lane_store_strobe_n,
  output logic                               high_lane_store_strobe_n,
  output logic [ebsu_pkg::AREA_N-1:0]        area_select_n,
  input  wire logic                          wait_req_n,
  output logic                               bus_clock
);
  import ebsu_pkg::*;

  ebsu_req_if rq ();

  ebsu_state_t                 st_q, st_d;
  logic                        wr_q, wr_d;
  logic [LANE_N-1:0]           ln_q, ln_d;
  logic [AREA_W-1:0]           ar_q, ar_d;
  logic [ADDR_W-1:0]           ad_q, ad_d;
  logic [DATA_W-1:0]           wd_q, wd_d;
  ebsu_mode_t                  md_q, md_d;
  logic                        rdy_q, rdy_d;
  logic                        rv_q, rv_d;
  logic [DATA_W-1:0]           rd_q, rd_d;
  logic [ADDR_W-1:0]           ao_q, ao_d;
  logic [DATA_W-1:0]           do_q, do_d;
  logic                        oe_q, oe_d;
  logic                        rds_q, rds_d;
  logic                        w0_q, w0_d;
  logic                        w1_q, w1_d;
  logic [AREA_N-1:0]           cs_q, cs_d;
  logic                        bclk_w;

  ebsu_bclk_gen u_bclk (
    .core_clk (core_clk),
    .rst      (rst),
    .bclk_q   (bclk_w),
    .rise_q   (rq.bclk_rise)
  );

  // Setup, strobe and hold advance on a bus clock rising edge so far devices see whole cycles; idle leaves on the accepted request
  always_comb begin
    st_d  = st_q;
    wr_d  = wr_q;
    ln_d  = ln_q;
    ar_d  = ar_q;
    ad_d  = ad_q;
    wd_d  = wd_q;
    md_d  = md_q;
    rdy_d = 1'b0;
    rv_d  = 1'b0;
    rd_d  = rd_q;
    case (st_q)
      EBSU_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && rdy_q) begin
          rdy_d = 1'b0;
          wr_d  = req_write;
          ln_d  = req_lanes;
          ar_d  = req_area;
          ad_d  = req_addr;
          wd_d  = req_wdata;
          md_d  = single_strobe_mode ? EBSU_MODE_SINGLE : EBSU_MODE_LANE; // RQ8
          st_d  = EBSU_SETUP;
        end
      end
      EBSU_SETUP: begin
        if (rq.bclk_rise) begin
          st_d = EBSU_STROBE;
        end
      end
      EBSU_STROBE: begin
        // Wait is looked at only on bus clock edges, as a far device would drive it
        if (rq.bclk_rise && wait_req_n) begin // RQ10
          st_d = EBSU_HOLD;
          if (!wr_q) begin
            rd_d = data_lines_in; // RQ12
            rv_d = 1'b1;
          end
        end
      end
      EBSU_HOLD: begin
        if (rq.bclk_rise) begin
          st_d  = EBSU_IDLE;
          rdy_d = 1'b1;
        end
      end
      default: st_d = EBSU_IDLE;
    endcase
  end

  assign rq.strobe_on = (st_q == EBSU_STROBE);
  assign rq.is_write  = wr_q;
  assign rq.lanes     = ln_q;
  assign rq.mode      = md_q;

  // Pin image, registered so every pin leaves straight from a flip-flop
  always_comb begin
    logic act;
    act  = (st_q != EBSU_IDLE);
    ao_d = act ? ad_q : ADDR_RST; // RQ11
    // In single mode the shared pin is an enable, so it must idle high like the others
    if (md_q == EBSU_MODE_SINGLE) begin
      ao_d[A0_BIT] = ~(act && ln_q[LANE_LO]); // RQ5 RQ6 RQ7 RQ14
    end
    do_d  = (act && wr_q) ? wd_q : DATA_RST; // RQ12
    oe_d  = act && wr_q; // RQ12
    cs_d  = AREA_IDLE;
    if (act) begin
      cs_d[ar_q] = 1'b0; // RQ9 RQ14
    end
    rds_d = ~(rq.strobe_on && !rq.is_write); // RQ1 RQ14
    w0_d  = 1'b1;
    w1_d  = 1'b1;
    if (rq.mode == EBSU_MODE_LANE) begin
      w0_d = ~(rq.strobe_on && rq.is_write && rq.lanes[LANE_LO]); // RQ2
      w1_d = ~(rq.strobe_on && rq.is_write && rq.lanes[LANE_HI]); // RQ3
    end else begin
      w0_d = ~(rq.strobe_on && rq.is_write); // RQ4
      w1_d = ~(act && rq.lanes[LANE_HI]); // RQ5 RQ6
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q  <= EBSU_IDLE;
      wr_q  <= 1'b0;
      ln_q  <= '0;
      ar_q  <= '0;
      ad_q  <= ADDR_RST;
      wd_q  <= DATA_RST;
      md_q  <= EBSU_MODE_LANE;
      rdy_q <= 1'b0;
      rv_q  <= 1'b0;
      rd_q  <= DATA_RST;
      ao_q  <= ADDR_RST;
      do_q  <= DATA_RST;
      oe_q  <= 1'b0;
      rds_q <= 1'b1;
      w0_q  <= 1'b1;
      w1_q  <= 1'b1;
      cs_q  <= AREA_IDLE;
    end else begin
      st_q  <= st_d;
      wr_q  <= wr_d;
      ln_q  <= ln_d;
      ar_q  <= ar_d;
      ad_q  <= ad_d;
      wd_q  <= wd_d;
      md_q  <= md_d;
      rdy_q <= rdy_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      ao_q  <= ao_d;
      do_q  <= do_d;
      oe_q  <= oe_d;
      rds_q <= rds_d;
      w0_q  <= w0_d;
      w1_q  <= w1_d;
      cs_q  <= cs_d;
    end
  end

  assign req_ready                = rdy_q;
  assign rsp_valid                = rv_q;
  assign rsp_rdata                = rd_q;
  assign address_lines            = ao_q;
  assign data_lines_out           = do_q;
  assign data_lines_oe            = oe_q;
  assign read_strobe_n            = rds_q;
  assign low_lane_store_strobe_n  = w0_q;
  assign high_lane_store_strobe_n = w1_q;
  assign area_select_n            = cs_q;
  assign bus_clock                = bclk_w; // RQ13

  a_read_strobe_idle: assert property (@(posedge core_clk) disable iff (rst) // RQ14
    (st_q == EBSU_IDLE) |=> (read_strobe_n && low_lane_store_strobe_n))
    else $error("strobe low while bus idle");
  a_read_strobe_low: assert property (@(posedge core_clk) disable iff (rst) // RQ1
    (st_q == EBSU_STROBE && !wr_q) |=> !read_strobe_n)
    else $error("read strobe high during read");
  a_low_lane_gate: assert property (@(posedge core_clk) disable iff (rst) // RQ2
    (md_q == EBSU_MODE_LANE && !ln_q[LANE_LO]) |=> low_lane_store_strobe_n)
    else $error("low lane strobe without low byte");
  a_high_lane_gate: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    (st_q == EBSU_STROBE && wr_q && md_q == EBSU_MODE_LANE && ln_q[LANE_HI])
      |=> !high_lane_store_strobe_n)
    else $error("high lane strobe missing");
  a_single_write: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    (st_q == EBSU_STROBE && wr_q && md_q == EBSU_MODE_SINGLE) |=> !low_lane_store_strobe_n)
    else $error("common write strobe missing");
  a_read_lane_enable: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    (st_q == EBSU_STROBE && !wr_q && md_q == EBSU_MODE_SINGLE && ln_q[LANE_HI])
      |=> !high_lane_store_strobe_n)
    else $error("high lane enable missing on read");
  a_area_onehot: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    (st_q != EBSU_IDLE) |=> (area_select_n == ~(AREA_N'(1) << $past(ar_q))))
    else $error("wrong area select");
  a_wait_stretch: assert property (@(posedge core_clk) disable iff (rst) // RQ10
    (st_q == EBSU_STROBE && !wait_req_n) |=> (st_q == EBSU_STROBE))
    else $error("access ended under wait");
  a_drive_on_write: assert property (@(posedge core_clk) disable iff (rst) // RQ12
    (st_q == EBSU_SETUP) |=> (data_lines_oe == $past(wr_q)))
    else $error("data drive mismatch");

  // Checks of idle levels, lane gating, address, data, wait handling, area selects and bus clock pacing
  a_high_strobe_idle: assert property (@(posedge core_clk) disable iff (rst) // RQ14
    (st_q == EBSU_IDLE) |=> high_lane_store_strobe_n)
    else $error("high strobe low while bus idle");
  a_area_idle: assert property (@(posedge core_clk) disable iff (rst) // RQ14
    (st_q == EBSU_IDLE) |=> (area_select_n == AREA_IDLE))
    else $error("area select low while bus idle");
  a_low_enable_idle: assert property (@(posedge core_clk) disable iff (rst) // RQ7
    (st_q == EBSU_IDLE && md_q == EBSU_MODE_SINGLE) |=> address_lines[A0_BIT])
    else $error("low lane enable low while bus idle");
  a_low_enable_on: assert property (@(posedge core_clk) disable iff (rst) // RQ5
    (st_q != EBSU_IDLE && md_q == EBSU_MODE_SINGLE)
      |=> (address_lines[A0_BIT] == !$past(ln_q[LANE_LO])))
    else $error("low lane enable wrong");
  a_high_enable_on: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    (st_q != EBSU_IDLE && md_q == EBSU_MODE_SINGLE)
      |=> (high_lane_store_strobe_n == !$past(ln_q[LANE_HI])))
    else $error("high lane enable wrong");
  a_addr_lane_mode: assert property (@(posedge core_clk) disable iff (rst) // RQ11
    (st_q != EBSU_IDLE && md_q == EBSU_MODE_LANE) |=> (address_lines == $past(ad_q)))
    else $error("address wrong in per-lane mode");
  a_addr_upper: assert property (@(posedge core_clk) disable iff (rst) // RQ11
    (st_q != EBSU_IDLE)
      |=> (address_lines[ADDR_W-1:A0_BIT+1] == $past(ad_q[ADDR_W-1:A0_BIT+1])))
    else $error("upper address wrong");
  a_low_lane_write: assert property (@(posedge core_clk) disable iff (rst) // RQ2
    (st_q == EBSU_STROBE && wr_q && md_q == EBSU_MODE_LANE && ln_q[LANE_LO])
      |=> !low_lane_store_strobe_n)
    else $error("low lane strobe missing");
  a_high_lane_quiet: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    (md_q == EBSU_MODE_LANE && !ln_q[LANE_HI]) |=> high_lane_store_strobe_n)
    else $error("high lane strobe without high byte");
  a_write_no_read: assert property (@(posedge core_clk) disable iff (rst) // RQ1
    wr_q |=> read_strobe_n)
    else $error("read strobe low during write");
  a_single_read_quiet: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    (!wr_q && md_q == EBSU_MODE_SINGLE) |=> low_lane_store_strobe_n)
    else $error("common write strobe low during read");
  a_read_no_drive: assert property (@(posedge core_clk) disable iff (rst) // RQ12
    (!wr_q || st_q == EBSU_IDLE) |=> !data_lines_oe)
    else $error("data lines driven outside a write");
  a_write_data_out: assert property (@(posedge core_clk) disable iff (rst) // RQ12
    (st_q != EBSU_IDLE && wr_q) |=> (data_lines_out == $past(wd_q)))
    else $error("write data wrong on data lines");
  a_read_capture: assert property (@(posedge core_clk) disable iff (rst) // RQ12
    (st_q == EBSU_STROBE && !wr_q && rq.bclk_rise && wait_req_n)
      |=> (rsp_valid && rsp_rdata == $past(data_lines_in)))
    else $error("read data not captured");
  a_wait_release: assert property (@(posedge core_clk) disable iff (rst) // RQ10
    (st_q == EBSU_STROBE && rq.bclk_rise && wait_req_n)
      |=> (st_q == EBSU_HOLD))
    else $error("strobe not ended after wait release");
  a_strobe_busy: assert property (@(posedge core_clk) disable iff (rst) // RQ10
    (st_q == EBSU_STROBE) |=> !req_ready)
    else $error("ready during strobe phase");
  a_bclk_edge: assert property (@(posedge core_clk) disable iff (rst) // RQ13
    ($rose(bus_clock) == rq.bclk_rise))
    else $error("bus clock edge and phase pulse disagree");
  a_bclk_pace: assert property (@(posedge core_clk) disable iff (rst) // RQ13
    rq.bclk_rise |=> (bus_clock ##1 !bus_clock ##1 !bus_clock ##1 bus_clock))
    else $error("bus clock pace wrong");
  a_area_single: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    $onehot0(~area_select_n))
    else $error("more than one area select low");
  a_strobe_in_area: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    !read_strobe_n |-> (area_select_n != AREA_IDLE))
    else $error("read strobe without area select");
endmodule : ebsu_top

// ===== tb/ebsu_far_mem.sv
// Far-side memory model: answers reads, stores writes, notes pins at strobe time
`timescale 1ns/100ps
module ebsu_far_mem (
  input  wire logic        core_clk,
  input  wire logic        single_strobe_mode,
  input  wire logic [23:0] address_lines,
  input  wire logic [15:0] data_lines_out,
  input  wire logic        data_lines_oe,
  input  wire logic        read_strobe_n,
  input  wire logic        low_lane_store_strobe_n,
  input  wire logic        high_lane_store_strobe_n,
  input  wire logic [7:0]  area_select_n,
  input  wire logic [31:0] wait_len,
  output logic [15:0]      data_lines_in,
  output logic             wait_req_n,
  output logic             s_rd,
  output logic             s_lo,
  output logic             s_hi,
  output logic             s_oe,
  output logic [23:0]      s_adr,
  output logic [15:0]      s_dat,
  output logic [7:0]       s_cs,
  output int               hits,
  output int               len
);
  logic [15:0] mem [int];
  logic [15:0] cur, v;
  logic [1:0]  wl;
  logic        hn, ln, act, act_q = 1'b0;
  int          wc = 0, k;
  initial begin
    data_lines_in = 16'h0000;
    wait_req_n = 1'b1;
    hits = 0;
    len = 0;
  end
  always @(posedge core_clk) begin
    hn = high_lane_store_strobe_n;
    ln = single_strobe_mode ? address_lines[0] : low_lane_store_strobe_n;
    act = !read_strobe_n || !low_lane_store_strobe_n || (!single_strobe_mode && !hn);
    wl = ~{hn, ln};
    k = int'(address_lines[23:1]);
    cur = mem.exists(k) ? mem[k] : 16'(k) ^ 16'ha5a5;
    v = data_lines_oe ? data_lines_out : ~data_lines_out;
    if (act && read_strobe_n) begin
      mem[k] = {wl[1] ? v[15:8] : cur[15:8], wl[0] ? v[7:0] : cur[7:0]};
    end
    // A released bus shows the inverse of its last value, never a held copy
    data_lines_in <= !read_strobe_n ? cur : ~data_lines_in;
    // Wait is held low for wait_len cycles from the second strobe cycle
    wait_req_n <= !(act && act_q && wc > 0);
    wc <= !act_q ? int'(wait_len) : (wc > 0 ? wc - 1 : 0);
    act_q <= act;
    if (act) begin
      hits <= act_q ? hits : hits + 1;
      len <= act_q ? len + 1 : 1;
      s_rd <= !read_strobe_n;
      s_lo <= !low_lane_store_strobe_n;
      s_hi <= !hn;
      s_oe <= data_lines_oe;
      s_adr <= address_lines;
      s_dat <= data_lines_out;
      s_cs <= area_select_n;
    end
  end
endmodule : ebsu_far_mem

// ===== tb/ebsu_top_tb.sv
// Self-checking bench of the external bus strobe unit against a reference memory
`timescale 1ns/100ps
module ebsu_top_tb;
  import ebsu_pkg::*;
  logic              core_clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic              single_strobe_mode = 0, req_ready, rsp_valid, data_lines_oe;
  logic              read_strobe_n, low_lane_store_strobe_n, high_lane_store_strobe_n;
  logic              wait_req_n, bus_clock, s_rd, s_lo, s_hi, s_oe, pb;
  logic [ADDR_W-1:0] req_addr = '0, address_lines, s_adr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_lines_out, data_lines_in, s_dat;
  logic [LANE_N-1:0] req_lanes = '0;
  logic [AREA_W-1:0] req_area = '0;
  logic [AREA_N-1:0] area_select_n, s_cs;
  logic [15:0]       ref_mem [int];
  int                wait_len = 0, hits, len, i, bc = 0, checks = 0, error_cnt = 0;
  bit                abort = 0;
  ebsu_top uut (.core_clk, .rst, .req_valid, .req_write, .req_addr, .req_lanes, .req_area,
    .req_wdata, .single_strobe_mode, .req_ready, .rsp_valid, .rsp_rdata, .address_lines,
    .data_lines_out, .data_lines_oe, .data_lines_in, .read_strobe_n, .low_lane_store_strobe_n,
    .high_lane_store_strobe_n, .area_select_n, .wait_req_n, .bus_clock);
  ebsu_far_mem far (.core_clk, .single_strobe_mode, .address_lines, .data_lines_out,
    .data_lines_oe, .read_strobe_n, .low_lane_store_strobe_n, .high_lane_store_strobe_n,
    .area_select_n, .wait_len, .data_lines_in, .wait_req_n, .s_rd, .s_lo, .s_hi, .s_oe,
    .s_adr, .s_dat, .s_cs, .hits, .len);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(bit ok, string s);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic op(bit wr, bit md, int w);
    logic [23:0] a;
    logic [15:0] x, m, d;
    logic [1:0]  ln;
    logic [2:0]  ar;
    bit          got;
    int          n, k, h;
    a = {1'($urandom), 19'h2_a5a5, 4'($urandom)};
    ln = 2'($urandom_range(3, 1));
    ar = 3'($urandom);
    d = 16'($urandom);
    m = {{8{ln[1]}}, {8{ln[0]}}};
    k = int'(a[23:1]);
    x = ref_mem.exists(k) ? ref_mem[k] : 16'(k) ^ 16'ha5a5;
    h = hits;
    got = 0;
    {req_write, req_addr, req_lanes, req_area, req_wdata} = {wr, a, ln, ar, d};
    {single_strobe_mode, wait_len, req_valid} = {md, w, 1'b1};
    for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(posedge core_clk) #2;
    if (req_ready !== 1'b1) begin
      chk(0, "request never taken");
      req_valid = 0;
      abort = 1;
      return;
    end
    @(posedge core_clk) #2;
    req_valid = 0;
    for (n = 0; n < 300 && req_ready !== 1'b1; n++) begin
      @(posedge core_clk) #2;
      if (rsp_valid === 1'b1) begin
        got = 1;
        chk(rsp_rdata === x, "read data");
      end
    end
    if (req_ready !== 1'b1) begin
      chk(0, "no return to ready");
      abort = 1;
      return;
    end
    @(posedge core_clk) #2;
    chk({read_strobe_n, low_lane_store_strobe_n, high_lane_store_strobe_n,
      area_select_n} === 11'h7ff && got == !wr, "idle pins");
    chk(address_lines === {{(ADDR_W-1){1'b0}}, md} && data_lines_oe === 1'b0,
      "idle address and drive");
    chk(hits == h + 1 && s_cs === ~(8'h01 << ar), "area select");
    chk(s_rd === !wr, "read strobe");
    chk(md ? s_hi === ln[1] && s_adr[0] === !ln[0] && s_adr[23:1] === a[23:1]
      : s_adr === a, "address and lane enables");
    if (w > 0) chk(len > w, "wait stretch");
    if (wr) begin
      chk(s_oe === 1'b1 && (s_dat & m) === (d & m), "write data");
      chk(md ? s_lo === 1'b1 : {s_hi, s_lo} === ln, "write strobes");
      ref_mem[k] = (x & ~m) | (d & m);
    end else chk(s_oe === 1'b0 && (md || {s_hi, s_lo} === 2'b00), "read lanes");
  endtask : op
  initial begin
    void'($urandom(32'h0594_3449));
    repeat (16) @(posedge core_clk);
    #2 rst = 0;
    pb = bus_clock;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk) #2;
      if (bus_clock === 1'b1 && pb === 1'b0) bc++;
      pb = bus_clock;
    end
    chk(bc == 10, "bus clock rate");
    for (i = 0; i < 8 && !abort; i++) op(i[0], i[1], 0);
    // Single mode only ever runs on the 16-bit bus here
    for (i = 0; i < 40 && !abort; i++) begin
      op($urandom_range(1), $urandom_range(1), $urandom_range(1) ? 0 : $urandom_range(12, 2));
    end
    wrap_up();
  end
endmodule : ebsu_top_tb
